// ### pkg/mlc_pkg.sv
// Shared types and constants for the multiply / logic / control execution unit.
// Assumes a decoder upstream that hands over one decoded instruction at a time.
`default_nettype none
package mlc_pkg;
  localparam int unsigned WORD_W     = 24;
  localparam int unsigned PROD_W     = 48;
  localparam int unsigned REG_N      = 4;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned CNT_W      = 5;
  // Execution cycle counts per opcode form
  localparam logic [4:0]  CYC_MULT   = 5'h1e; // 30
  localparam logic [4:0]  CYC_NAND_R = 5'h03;
  localparam logic [4:0]  CYC_NAND_K = 5'h06;
  localparam logic [4:0]  CYC_START  = 5'h03;
  localparam logic [4:0]  CYC_NOP    = 5'h01;
  // Code length in bytes per opcode form
  localparam logic [2:0]  LEN_MULT   = 3'h2;
  localparam logic [2:0]  LEN_NAND_R = 3'h2;
  localparam logic [2:0]  LEN_NAND_K = 3'h5;
  localparam logic [2:0]  LEN_START  = 3'h2;
  localparam logic [2:0]  LEN_NOP    = 3'h1;
  localparam logic [23:0] WORD_ZERO  = 24'h000000;

  typedef enum logic [2:0] {
    OP_NOP      = 3'b000,
    OP_MUL_HIGH = 3'b001,
    OP_MUL_FULL = 3'b010,
    OP_NAND     = 3'b011,
    OP_MEAS     = 3'b100
  } mlc_op_e;

  // One decoded instruction
  typedef struct packed {
    mlc_op_e             op;
    logic [SEL_W-1:0]    first_operand;
    logic [SEL_W-1:0]    second_operand;
    logic                use_const;
    logic [WORD_W-1:0]   constant;
  } mlc_instr_s;

  // Condition flags
  typedef struct packed {
    logic sign;
    logic zero;
  } mlc_flags_s;
endpackage
`default_nettype wire

// ### hw/mlc_mult.sv
// Signed 24x24 multiplier, result registered one cycle after the operands.
// Assumes operands are held stable by the caller while the result is used.
`default_nettype none
module mlc_mult
  import mlc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Operands
  input  wire logic [WORD_W-1:0] a_i,
  input  wire logic [WORD_W-1:0] b_i,
  // Product
  output logic      [PROD_W-1:0] prod_o
);
  logic [PROD_W-1:0] prod_r;
  logic [PROD_W-1:0] prod_nxt;
  logic [PROD_W-1:0] a_ext;
  logic [PROD_W-1:0] b_ext;

  // twos-complement operands, sign-extended so the low 48 product bits are exact
  always_comb begin
    a_ext    = {{WORD_W{a_i[WORD_W-1]}}, a_i};
    b_ext    = {{WORD_W{b_i[WORD_W-1]}}, b_i};
    prod_nxt = a_ext * b_ext;
  end

  // Product register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      prod_r <= '0;
    end else begin
      prod_r <= prod_nxt;
    end
  end

  assign prod_o = prod_r;
endmodule
`default_nettype wire

// ### hw/mlc_exec.sv
// Execution unit for multiply, NAND, measurement start and no-operation.
// Assumes the decoder presents an instruction with start_i only while busy_o is low.
`default_nettype none
module mlc_exec
  import mlc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Instruction issue
  input  wire logic              start_i,
  input  var  mlc_instr_s        instr_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [2:0]             code_len_o,
  // Architectural state
  output logic [WORD_W-1:0]      work_register_o [REG_N],
  output mlc_flags_s             flags_o,
  // Converter trigger
  output logic                   interval_timer_core_start_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } mlc_state_e;

  mlc_state_e        state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  mlc_instr_s        ins_r, ins_nxt;
  logic [WORD_W-1:0] wreg_r [REG_N];
  logic [WORD_W-1:0] wreg_nxt [REG_N];
  mlc_flags_s        flags_r, flags_nxt;
  logic [2:0]        len_r, len_nxt;
  logic              trig_r, trig_nxt;
  logic              done_r, done_nxt;
  logic [PROD_W-1:0] prod;
  logic [WORD_W-1:0] opnd_b;

  // Cycle count for an opcode form
  function automatic logic [4:0] cycles_of(input mlc_instr_s i);
    case (i.op)
      OP_MUL_HIGH, OP_MUL_FULL: cycles_of = CYC_MULT;
      OP_NAND:  cycles_of = i.use_const ? CYC_NAND_K : CYC_NAND_R;
      OP_MEAS:  cycles_of = CYC_START;
      default:  cycles_of = CYC_NOP;
    endcase
  endfunction

  // Code length for an opcode form
  function automatic logic [2:0] length_of(input mlc_instr_s i);
    case (i.op)
      OP_MUL_HIGH, OP_MUL_FULL: length_of = LEN_MULT;
      OP_NAND:  length_of = i.use_const ? LEN_NAND_K : LEN_NAND_R;
      OP_MEAS:  length_of = LEN_START;
      default:  length_of = LEN_NOP;
    endcase
  endfunction

  // Flags from the value landing in the first operand
  function automatic mlc_flags_s flags_of(input logic [WORD_W-1:0] v);
    flags_of.sign = v[WORD_W-1];
    flags_of.zero = (v == WORD_ZERO);
  endfunction

  assign opnd_b = ins_r.use_const ? ins_r.constant : wreg_r[ins_r.second_operand];

  // Multiplier sees latched operands; product settles long before the last cycle
  mlc_mult u_mult (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .a_i     (wreg_r[ins_r.first_operand]),
    .b_i     (wreg_r[ins_r.second_operand]),
    .prod_o  (prod)
  );

  // Sequencer and writeback
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ins_nxt   = ins_r;
    wreg_nxt  = wreg_r;
    flags_nxt = flags_r;
    len_nxt   = len_r;
    trig_nxt  = 1'b0;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start_i) begin
          ins_nxt   = instr_i;
          cnt_nxt   = cycles_of(instr_i);
          len_nxt   = length_of(instr_i);
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_nxt = cnt_r - 5'h01;
        if (ins_r.op == OP_MEAS && cnt_r == CYC_START) begin
          trig_nxt = 1'b1;
        end
        if (cnt_r == 5'h01) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
          case (ins_r.op)
            OP_MUL_HIGH: begin
              wreg_nxt[ins_r.first_operand] = prod[PROD_W-1:WORD_W];
              flags_nxt = flags_of(prod[PROD_W-1:WORD_W]);
            end
            OP_MUL_FULL: begin
              wreg_nxt[ins_r.second_operand] = prod[WORD_W-1:0];
              wreg_nxt[ins_r.first_operand]  = prod[PROD_W-1:WORD_W];
              flags_nxt = flags_of(prod[PROD_W-1:WORD_W]);
            end
            OP_NAND: begin
              wreg_nxt[ins_r.first_operand] = ~(wreg_r[ins_r.first_operand] & opnd_b);
              flags_nxt = flags_of(~(wreg_r[ins_r.first_operand] & opnd_b));
            end
            default: ;
          endcase
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      ins_r   <= '0;
      wreg_r  <= '{default: '0};
      flags_r <= '0;
      len_r   <= '0;
      trig_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ins_r   <= ins_nxt;
      wreg_r  <= wreg_nxt;
      flags_r <= flags_nxt;
      len_r   <= len_nxt;
      trig_r  <= trig_nxt;
      done_r  <= done_nxt;
    end
  end

  assign code_len_o                  = len_r;
  assign busy_o                      = (state_r == ST_RUN);
  assign done_o                      = done_r;
  assign work_register_o             = wreg_r;
  assign flags_o                     = flags_r;
  // Converter trigger, one clock wide; no gating here, issue order is the program's job
  assign interval_timer_core_start_o = trig_r;

  // Busy cycles of the current instruction, for the length bound below
  logic [CNT_W-1:0] busy_cnt_r, busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = busy_o ? busy_cnt_r + 5'h01 : '0;
  end

  // Busy counter register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  sequence s_issue_mult;
    start_i && !busy_o && (instr_i.op == OP_MUL_HIGH || instr_i.op == OP_MUL_FULL);
  endsequence

  a_mult_thirty: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_issue_mult |=> busy_o [*8] ##23 done_o)
    else $error("multiply did not finish in 30 cycles");

  a_nop_one: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (start_i && !busy_o && instr_i.op == OP_NOP) |=> busy_o ##1 (done_o && $stable(flags_o)))
    else $error("nop not one cycle");

  a_nand_reg: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (start_i && !busy_o && instr_i.op == OP_NAND && !instr_i.use_const) |=> ##3 done_o)
    else $error("register nand not 3 cycles");

  a_nand_const: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (start_i && !busy_o && instr_i.op == OP_NAND && instr_i.use_const)
    |=> (code_len_o == LEN_NAND_K) ##6 done_o)
    else $error("constant nand not 6 cycles or 5 bytes");

  a_meas_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (start_i && !busy_o && instr_i.op == OP_MEAS)
    |=> !interval_timer_core_start_o ##1 interval_timer_core_start_o ##1
        !interval_timer_core_start_o ##1
        (!interval_timer_core_start_o && done_o && $stable(flags_o)))
    else $error("measurement start pulse wrong");

  a_nand_value: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (done_o && ins_r.op == OP_NAND)
    |-> work_register_o[ins_r.first_operand]
        == ~($past(wreg_r[ins_r.first_operand]) & $past(opnd_b)))
    else $error("nand result wrong");

  a_high_value: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (done_o && ins_r.op == OP_MUL_HIGH)
    |-> work_register_o[ins_r.first_operand] == $past(prod[PROD_W-1:WORD_W]))
    else $error("high multiply result wrong");

  a_full_low: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (done_o && ins_r.op == OP_MUL_FULL && ins_r.first_operand != ins_r.second_operand)
    |-> work_register_o[ins_r.second_operand] == $past(prod[WORD_W-1:0]))
    else $error("full multiply low half wrong");

  a_flags_sign: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (done_o && (ins_r.op == OP_MUL_HIGH || ins_r.op == OP_MUL_FULL))
    |-> flags_o.sign == work_register_o[ins_r.first_operand][WORD_W-1])
    else $error("sign flag wrong");

  a_busy_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    busy_o |-> busy_cnt_r < CYC_MULT)
    else $error("busy too long");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the multiply / logic / control execution unit.
// Assumes mlc_exec takes start_i only while busy_o is low.
`default_nettype none
module tb_top
  import mlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock_i = 1'b0;
  logic              rst_b_i, start_i, busy_o, done_o, trig_o;
  logic [2:0]        code_len_o;
  mlc_instr_s        instr_i;
  logic [WORD_W-1:0] work_register_o [REG_N];
  mlc_flags_s        flags_o, mf;
  logic [WORD_W-1:0] m [REG_N];
  logic signed [47:0] p;
  int                num_errors = 0;
  int                check_count = 0;

  // Free-running 200 MHz clock
  always #2.5 clock_i = ~clock_i;

  mlc_exec u_dut (
    .clock_i                     (clock_i),
    .rst_b_i                     (rst_b_i),
    .start_i                     (start_i),
    .instr_i                     (instr_i),
    .busy_o                      (busy_o),
    .done_o                      (done_o),
    .code_len_o                  (code_len_o),
    .work_register_o             (work_register_o),
    .flags_o                     (flags_o),
    .interval_timer_core_start_o (trig_o)
  );

  // Verdict and end of run, shared with the watchdog
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Model write; flags always follow the last value put
  task automatic put(input logic [1:0] r, input logic [23:0] v);
    m[r] = v;
    mf.sign = v[23];
    mf.zero = (v == WORD_ZERO);
  endtask

  task automatic check_state();
    for (int i = 0; i < REG_N; i++) chk("work_register", {24'h0, m[i]}, {24'h0, work_register_o[i]});
    chk("flags", {46'h0, mf}, {46'h0, flags_o});
  endtask

  // Issue one instruction and time it; poke tries a refused start mid-run
  task automatic run_op(input mlc_op_e op, input logic [1:0] f, input logic [1:0] s,
                        input logic uc, input logic [23:0] k, input int n,
                        input logic [2:0] len, input logic poke);
    int cyc;
    int trig;
    instr_i = '{op: op, first_operand: f, second_operand: s, use_const: uc, constant: k};
    start_i = 1'b1;
    @(posedge clock_i);
    #1;
    start_i = 1'b0;
    cyc = 0;
    trig = 0;
    while (done_o !== 1'b1 && cyc < 40) begin
      chk("busy_high", 48'h1, {47'h0, busy_o});
      if (trig_o === 1'b1) trig++;
      if (poke && cyc == 4) begin
        instr_i = '{op: OP_NAND, first_operand: 2'h3, second_operand: 2'h3,
                    use_const: 1'b1, constant: 24'h000000};
        start_i = 1'b1;
      end
      if (poke && cyc == 5) start_i = 1'b0;
      @(posedge clock_i);
      #1;
      cyc++;
    end
    if (trig_o === 1'b1) trig++;
    chk("latency", 48'(n), 48'(cyc));
    chk("busy_low", 48'h0, {47'h0, busy_o});
    chk("code_len", {45'h0, len}, {45'h0, code_len_o});
    chk("trigger_count", 48'(op == OP_MEAS), 48'(trig));
  endtask

  // Load a value with two constant NANDs: all-ones first, then the value
  task automatic load(input logic [1:0] r, input logic [23:0] v);
    run_op(OP_NAND, r, r, 1'b1, 24'h000000, 6, 3'h5, 1'b0);
    put(r, 24'hffffff);
    check_state();
    run_op(OP_NAND, r, r, 1'b1, ~v, 6, 3'h5, 1'b0);
    put(r, v);
    check_state();
  endtask

  // Power-up reset: outputs and work registers clear
  task automatic test_reset();
    rst_b_i = 1'b0;
    start_i = 1'b0;
    instr_i = '0;
    for (int i = 0; i < REG_N; i++) m[i] = 24'h000000;
    mf = '0;
    repeat (4) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    check_state();
    chk("reset_outputs", 48'h0, {42'h0, busy_o, done_o, trig_o, code_len_o});
  endtask

  // High word only, with a refused start in mid-run
  task automatic test_mult_high();
    load(2'h0, 24'h123456);
    load(2'h1, 24'hfedcba);
    p = $signed(m[0]) * $signed(m[1]);
    run_op(OP_MUL_HIGH, 2'h0, 2'h1, 1'b0, 24'h0, 30, 3'h2, 1'b1);
    put(2'h0, p[47:24]);
    check_state();
  endtask

  // Full product split over two registers
  task automatic test_mult_full();
    p = $signed(m[1]) * $signed(m[0]);
    run_op(OP_MUL_FULL, 2'h1, 2'h0, 1'b0, 24'h0, 30, 3'h2, 1'b0);
    put(2'h0, p[23:0]);
    put(2'h1, p[47:24]);
    check_state();
  endtask

  // NAND of two registers
  task automatic test_nand_reg();
    load(2'h2, 24'h0f0f0f);
    load(2'h3, 24'h00ffff);
    run_op(OP_NAND, 2'h2, 2'h3, 1'b0, 24'h0, 3, 3'h2, 1'b0);
    put(2'h2, ~(m[2] & m[3]));
    check_state();
  endtask

  // Converter trigger, issued only once the registers are set up
  task automatic test_meas_start();
    load(2'h3, 24'h000000);
    run_op(OP_MEAS, 2'h0, 2'h1, 1'b0, 24'h0, 3, 3'h2, 1'b0);
    check_state();
  endtask

  // Reset in the middle of a multiply clears everything
  task automatic test_reset_mid();
    instr_i = '{op: OP_MUL_FULL, first_operand: 2'h0, second_operand: 2'h1,
                use_const: 1'b0, constant: 24'h000000};
    start_i = 1'b1;
    @(posedge clock_i);
    #1;
    start_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    rst_b_i = 1'b0;
    @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    for (int i = 0; i < REG_N; i++) m[i] = 24'h000000;
    mf = '0;
    check_state();
    chk("reset_mid_outputs", 48'h0, {42'h0, busy_o, done_o, trig_o, code_len_o});
  endtask

  // No-operation, then done must have dropped again
  task automatic test_nop();
    run_op(OP_NOP, 2'h2, 2'h0, 1'b0, 24'h0, 1, 3'h1, 1'b0);
    check_state();
    @(posedge clock_i);
    #1;
    chk("done_pulse", 48'h0, {47'h0, done_o});
  endtask

  // Main sequence, operations issued back to back in done cycles, except the first one after each reset
  initial begin
    test_reset();
    test_mult_high();
    test_mult_full();
    test_nand_reg();
    test_meas_start();
    test_reset_mid();
    test_nop();
    complete_run();
  end

  // Watchdog well beyond the roughly 150 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
`default_nettype wire
